// File: logic/cvp_packetizer.sv
// Purpose: register file, test image source and iso packet framer
// Assumes: link layer delivers quadlet requests one cycle each
// Notes: payload per packet is programmed by host, checked here
`timescale 1ns/10ps
`default_nettype none
module cvp_packetizer #(
  parameter bit SMALL_SENSOR = 1'b0,
  parameter bit COLOR_CAM = 1'b0,
  parameter logic [9:0] MY_BUS = 10'h3ff, // arbitrary
  parameter logic [5:0] MY_NODE = 6'h00, // arbitrary
  parameter int CYCLE_LEN = cvp_pkg::CYCLE_CLKS
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire cvp_pkg::cvp_req_t req,
  input wire logic [7:0] sensorPixel,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic initPulse,
  output cvp_pkg::cvp_pix_t pixOut,
  output logic streaming
);
  logic [31:0] frameRate_r, videoMode_r, videoFormat_r, trigger_r;
  logic streamEn_r, active_r, init_r, rdValid_r, cfgErr_r;
  logic [1:0] testSel_r;
  logic [15:0] roiW_r, roiH_r, x_r, y_r;
  logic [12:0] pktBytes_r, byteCnt_r;
  logic [15:0] pktCnt_r;
  logic [7:0] moveOfs_r;
  logic [31:0] rdData_r;
  logic [12:0] cycCnt_r;
  cvp_pkg::cvp_pix_t pix_r;
  // address decode: own node, all-ones field
  wire hit = req.addr.busNumber == MY_BUS && req.addr.nodeNumber == MY_NODE
    && req.addr.highOnes == cvp_pkg::ADDR_HIGH_ONES;
  wire wrHit = req.wr && hit;
  wire [31:0] ofs = req.addr.offset;
  wire [31:0] totalPix = roiW_r * roiH_r;
  wire [31:0] pktsNeed = (totalPix + {19'h0, pktBytes_r} - 32'h1)
    / ({19'h0, pktBytes_r} | 32'h1);
  wire [15:0] pktLimit = SMALL_SENSOR ? cvp_pkg::SMALL_MAX_PACKETS
    : cvp_pkg::MAX_PACKETS;
  wire cfgOk = pktBytes_r != 13'h0 && pktBytes_r <= cvp_pkg::MAX_PAYLOAD
    && pktBytes_r[1:0] == 2'h0 && pktsNeed <= {16'h0, pktLimit};
  wire cycTick = cycCnt_r == 13'(CYCLE_LEN - 1);
  wire lastCol = x_r == roiW_r - 16'h1;
  wire lastRow = y_r == roiH_r - 16'h1;
  wire lastPix = lastCol && lastRow;
  // one byte per pixel in both 8-bit formats
  wire pktFull = byteCnt_r + 13'(cvp_pkg::BYTES_PER_PIXEL)
    >= pktBytes_r;
  wire inPkt = byteCnt_r != 13'h0;
  wire goFrame = !active_r && streamEn_r && cfgOk && cycTick;
  // moving image rolls upward by adding offset to row
  wire [7:0] rowVal = y_r[7:0] + (testSel_r == 2'h2 ? moveOfs_r : 8'h0);
  wire [7:0] testVal = x_r[7:0] + rowVal;
  // color camera passes raw mosaic data, no luminance
  wire [7:0] pixVal = testSel_r != 2'h0 ? testVal : sensorPixel;
  wire emit = active_r && (inPkt || cycTick);
  // register writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameRate_r <= cvp_pkg::RST_ZERO;
      videoMode_r <= cvp_pkg::RST_ZERO;
      videoFormat_r <= cvp_pkg::RST_ZERO;
      trigger_r <= cvp_pkg::RST_ZERO;
      streamEn_r <= 1'b0;
      testSel_r <= 2'h0;
      roiW_r <= 16'h0;
      roiH_r <= 16'h0;
      pktBytes_r <= 13'h0;
      init_r <= 1'b0;
    end else if (clkEn) begin
      init_r <= wrHit && ofs == cvp_pkg::OFS_INIT
        && req.data[cvp_pkg::MSB_POS];
      if (init_r) begin
        streamEn_r <= 1'b0;
        testSel_r <= 2'h0;
      end else if (wrHit) begin
        case (ofs)
          cvp_pkg::OFS_FRAME_RATE: frameRate_r <= req.data;
          cvp_pkg::OFS_VIDEO_MODE: videoMode_r <= req.data;
          cvp_pkg::OFS_VIDEO_FORMAT: videoFormat_r <= req.data;
          cvp_pkg::OFS_TRIGGER_MODE: trigger_r <= req.data;
          // msb is bit 0 of a big-endian register
          cvp_pkg::OFS_STREAM_ENABLE:
            streamEn_r <= req.data[cvp_pkg::MSB_POS];
          cvp_pkg::OFS_TEST_IMAGE: testSel_r <= req.data[1:0];
          cvp_pkg::OFS_ROI_SIZE: begin
            roiW_r <= req.data[31:16];
            roiH_r <= req.data[15:0];
          end
          cvp_pkg::OFS_PKT_BYTES: pktBytes_r <= req.data[12:0];
          default: ;
        endcase
      end
    end
  end
  // read mux
  logic [31:0] rdMux;
  always_comb begin
    case (ofs)
      cvp_pkg::OFS_FRAME_RATE: rdMux = frameRate_r;
      cvp_pkg::OFS_VIDEO_MODE: rdMux = videoMode_r;
      cvp_pkg::OFS_VIDEO_FORMAT: rdMux = videoFormat_r;
      cvp_pkg::OFS_TRIGGER_MODE: rdMux = trigger_r;
      cvp_pkg::OFS_STREAM_ENABLE: rdMux = {streamEn_r, 31'h0};
      cvp_pkg::OFS_TEST_IMAGE: rdMux = {30'h0, testSel_r};
      cvp_pkg::OFS_ROI_SIZE: rdMux = {roiW_r, roiH_r};
      cvp_pkg::OFS_PKT_BYTES: rdMux = {19'h0, pktBytes_r};
      cvp_pkg::OFS_STATUS: rdMux = {active_r, cfgErr_r, COLOR_CAM,
        13'h0, pktCnt_r};
      default: rdMux = 32'h0;
    endcase
  end
  // read answer and isochronous cycle timer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= 32'h0;
      rdValid_r <= 1'b0;
      cycCnt_r <= 13'h0;
    end else if (clkEn) begin
      rdValid_r <= req.rd && hit;
      if (req.rd && hit) rdData_r <= rdMux;
      cycCnt_r <= cycTick ? 13'h0 : cycCnt_r + 13'h1;
    end
  end
  // frame and packet framer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_r <= 1'b0;
      x_r <= 16'h0;
      y_r <= 16'h0;
      byteCnt_r <= 13'h0;
      pktCnt_r <= 16'h0;
      moveOfs_r <= 8'h0;
      cfgErr_r <= 1'b0;
      pix_r <= '0;
    end else if (clkEn) begin
      cfgErr_r <= streamEn_r && !cfgOk;
      pix_r.valid <= emit;
      pix_r.sof <= emit && x_r == 16'h0 && y_r == 16'h0;
      pix_r.sop <= emit && !inPkt;
      pix_r.eop <= emit && (pktFull || lastPix);
      pix_r.pixel <= pixVal;
      if (goFrame) begin
        active_r <= 1'b1;
        pktCnt_r <= 16'h0;
      end
      if (emit) begin
        byteCnt_r <= (pktFull || lastPix) ? 13'h0
          : byteCnt_r + 13'(cvp_pkg::BYTES_PER_PIXEL);
        if (pktFull || lastPix) pktCnt_r <= pktCnt_r + 16'h1;
        x_r <= lastCol ? 16'h0 : x_r + 16'h1;
        if (lastCol) y_r <= lastRow ? 16'h0 : y_r + 16'h1;
        // frame runs to its end even if stream is cleared
        if (lastPix) begin
          active_r <= 1'b0;
          moveOfs_r <= moveOfs_r + 8'h1;
        end
      end
    end
  end
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign initPulse = init_r;
  assign pixOut = pix_r;
  assign streaming = active_r;
  // checks
  payload_limit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    byteCnt_r <= cvp_pkg::MAX_PAYLOAD)
    else $error("payload over limit");
  packet_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pktCnt_r <= pktLimit)
    else $error("too many packets");
  quad_size_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    goFrame |-> pktBytes_r[1:0] == 2'h0)
    else $error("payload not quadlet");
  ramp_value_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clkEn && emit && testSel_r == 2'h1 |=> pix_r.pixel ==
    8'($past(x_r) + $past(y_r)))
    else $error("ramp mismatch");
  move_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clkEn && emit && lastPix |=> moveOfs_r == 8'($past(moveOfs_r) + 8'h1))
    else $error("offset step wrong");
  frame_finish_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    active_r && !(clkEn && emit && lastPix) |=> active_r)
    else $error("frame cut short");
  stream_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clkEn && !init_r && wrHit && ofs == cvp_pkg::OFS_STREAM_ENABLE
    |=> streamEn_r == $past(req.data[31]))
    else $error("enable not stored");
  init_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    clkEn && wrHit && ofs == cvp_pkg::OFS_INIT && req.data[31]
    |=> initPulse ##1 !streamEn_r)
    else $error("init missed");
  frame_run_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    active_r ##1 !active_r);
  packet_end_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    pix_r.eop && !pix_r.sof);
  moving_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    testSel_r == 2'h2 && moveOfs_r == 8'h2);
endmodule : cvp_packetizer
`default_nettype wire

// File: logic/cvp_pkg.sv
// Purpose: constants and carrier types for the iso video packetizer
// Assumes: 32-bit big-endian quadlet register access from the link layer
// Notes: bit 0 of a register is its most significant bit
package cvp_pkg;
  localparam logic [31:0] OFS_INIT = 32'h0000_0000;
  localparam logic [31:0] OFS_FRAME_RATE = 32'h0000_0600;
  localparam logic [31:0] OFS_VIDEO_MODE = 32'h0000_0604;
  localparam logic [31:0] OFS_VIDEO_FORMAT = 32'h0000_0608;
  localparam logic [31:0] OFS_TRIGGER_MODE = 32'h0000_0830;
  localparam logic [31:0] OFS_STREAM_ENABLE = 32'h0000_0614;
  localparam logic [31:0] OFS_TEST_IMAGE = 32'h0000_1000;
  localparam logic [31:0] OFS_ROI_SIZE = 32'h0000_1004;
  localparam logic [31:0] OFS_PKT_BYTES = 32'h0000_1008;
  localparam logic [31:0] OFS_STATUS = 32'h0000_100c;
  localparam logic [15:0] ADDR_HIGH_ONES = 16'hffff;
  localparam int MSB_POS = 31;
  localparam int CODE_SHIFT = 29;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [12:0] MAX_PAYLOAD = 13'h1000;
  localparam logic [15:0] MAX_PACKETS = 16'hffff;
  localparam logic [15:0] SMALL_MAX_PACKETS = 16'h0320;
  localparam real CYCLE_US = 125.0;
  localparam real CLK_MHZ = 40.0;
  localparam int CYCLE_CLKS = int'(CYCLE_US * CLK_MHZ);
  localparam logic [1:0] BYTES_PER_PIXEL = 2'h1;
  typedef struct packed {
    logic [9:0] busNumber;
    logic [5:0] nodeNumber;
    logic [15:0] highOnes;
    logic [31:0] offset;
  } cvp_addr_t;
  typedef struct packed {
    logic wr;
    logic rd;
    cvp_addr_t addr;
    logic [31:0] data;
  } cvp_req_t;
  typedef struct packed {
    logic valid;
    logic sof;
    logic sop;
    logic eop;
    logic [7:0] pixel;
  } cvp_pix_t;
endpackage : cvp_pkg

// File: tb/cvp_host_model.sv
// Purpose: host side of the register path, quadlet writes and reads
// Assumes: one request per enabled cycle, answer one cycle later
// Notes: data lines invert once released so stale values never match
`timescale 1ns/10ps
`default_nettype none
module cvp_host_model (
  input wire logic sys_clk,
  input wire logic [31:0] rdData,
  input wire logic rdValid,
  output cvp_pkg::cvp_req_t req
);
  initial req = '0;
  // one quadlet request held for a single cycle
  task automatic xfer(input logic w, input logic [5:0] node,
                      input logic [31:0] ofs, input logic [31:0] d);
    @(posedge sys_clk);
    req.wr <= w;
    req.rd <= !w;
    req.addr.busNumber <= 10'h3ff;
    req.addr.nodeNumber <= node;
    req.addr.highOnes <= cvp_pkg::ADDR_HIGH_ONES;
    req.addr.offset <= ofs;
    req.data <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    req.data <= ~d;
  endtask : xfer
  // read, answer sampled once the answering edge has landed
  task automatic rd(input logic [5:0] node, input logic [31:0] ofs,
                    output logic [31:0] d, output logic v);
    xfer(1'b0, node, ofs, 32'h0000_0000);
    #1;
    d = rdData;
    v = rdValid;
  endtask : rd
  // mode codes sit in the top three bits, trigger written then cleared to zero
  task automatic configure();
    xfer(1'b1, 6'h00, cvp_pkg::OFS_FRAME_RATE, 32'h2 << 29);
    xfer(1'b1, 6'h00, cvp_pkg::OFS_VIDEO_MODE, 32'h0 << 29);
    xfer(1'b1, 6'h00, cvp_pkg::OFS_VIDEO_FORMAT, 32'h7 << 29);
    xfer(1'b1, 6'h00, cvp_pkg::OFS_TRIGGER_MODE, 32'h8200_0000);
    xfer(1'b1, 6'h00, cvp_pkg::OFS_TRIGGER_MODE, 32'h0000_0000);
  endtask : configure
endmodule : cvp_host_model
`default_nettype wire

// File: tb/test_camera_iso_video_packetizer.sv
// Purpose: self-checking bench for the iso video packetizer
// Assumes: 4x3 region, 4-byte packets, short iso cycle
// Notes: test image pixels checked against the diagonal ramp
`timescale 1ns/10ps
`default_nettype none
module test_camera_iso_video_packetizer;
  logic sysClk;
  logic arstN;
  logic clkEn;
  logic [7:0] sensorPixel;
  cvp_pkg::cvp_req_t req;
  logic [31:0] rdData;
  logic rdValid;
  logic initPulse;
  cvp_pkg::cvp_pix_t pixOut;
  logic streaming;
  logic [31:0] d;
  logic v;
  logic [7:0] a;
  logic [7:0] b;
  int numErrors;
  int checks;
  cvp_packetizer #(.CYCLE_LEN(20)) i_dut (.sys_clk(sysClk), .arst_n(arstN),
    .clkEn(clkEn), .req(req), .sensorPixel(sensorPixel), .rdData(rdData),
    .rdValid(rdValid), .initPulse(initPulse), .pixOut(pixOut),
    .streaming(streaming));
  cvp_host_model i_host (.sys_clk(sysClk), .rdData(rdData),
    .rdValid(rdValid), .req(req));
  // clock, 25 ns period
  initial begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wr(input logic [31:0] ofs, input logic [31:0] dat);
    i_host.xfer(1'b1, 6'h00, ofs, dat);
  endtask : wr
  // collect one frame, return its ramp offset
  task automatic grab(output logic [7:0] off);
    int n, eops, k;
    n = 0;
    eops = 0;
    off = 8'h00;
    for (k = 0; k < 400 && n < 12; k++) begin
      @(posedge sysClk);
      #1;
      if (pixOut.valid === 1'b1 && (n > 0 || pixOut.sof === 1'b1)) begin
        if (n == 0) off = pixOut.pixel;
        check(pixOut.pixel, 8'(n % 4 + n / 4 + off), "ramp");
        check(pixOut.sop, n % 4 == 0, "packet start");
        if (n < 11) check(streaming, 1'b1, "frame cut");
        if (pixOut.eop === 1'b1) eops++;
        n++;
      end
    end
    check(eops, 3, "packet count");
    if (n != 12) begin
      numErrors++;
      $display("wrong value at %0t: frame timeout", $time);
      end_sim();
    end
  endtask : grab
  task automatic t_regs();
    i_host.configure();
    wr(cvp_pkg::OFS_ROI_SIZE, {16'h0004, 16'h0003});
    wr(cvp_pkg::OFS_PKT_BYTES, 32'h0000_0004);
    wr(cvp_pkg::OFS_TEST_IMAGE, 32'h0000_0001);
    wr(cvp_pkg::OFS_STREAM_ENABLE, 32'h8000_0000);
    i_host.rd(6'h00, cvp_pkg::OFS_STREAM_ENABLE, d, v);
    check(d, 32'h8000_0000, "stream enable readback");
    i_host.rd(6'h05, cvp_pkg::OFS_STREAM_ENABLE, d, v);
    check(v, 1'b0, "foreign node answered");
  endtask : t_regs
  task automatic t_images();
    grab(a);
    grab(b);
    check({a, b}, 16'h0000, "static offset");
    wr(cvp_pkg::OFS_TEST_IMAGE, 32'h0000_0002);
    grab(a);
    grab(a);
    grab(b);
    check(b, a + 8'h01, "moving step");
  endtask : t_images
  task automatic t_init();
    int k;
    wr(cvp_pkg::OFS_INIT, 32'h8000_0000);
    #1;
    for (k = 0; k < 4 && initPulse !== 1'b1; k++) begin
      @(posedge sysClk);
      #1;
    end
    check(initPulse, 1'b1, "init pulse");
    i_host.rd(6'h00, cvp_pkg::OFS_STREAM_ENABLE, d, v);
    check(d, 32'h0000_0000, "init clears stream");
  endtask : t_init
  // oversize and non-quadlet payloads must flag a configuration error
  task automatic t_bad(input logic [31:0] bytes);
    wr(cvp_pkg::OFS_PKT_BYTES, bytes);
    wr(cvp_pkg::OFS_STREAM_ENABLE, 32'h8000_0000);
    repeat (50) @(posedge sysClk);
    i_host.rd(6'h00, cvp_pkg::OFS_STATUS, d, v);
    check(d[30], 1'b1, "bad payload accepted");
    wr(cvp_pkg::OFS_INIT, 32'h8000_0000);
  endtask : t_bad
  // reset, then the scenarios in turn
  initial begin
    arstN = 1'b0;
    clkEn = 1'b1;
    sensorPixel = 8'h00;
    numErrors = 0;
    checks = 0;
    repeat (16) @(posedge sysClk);
    arstN <= 1'b1;
    t_regs();
    t_images();
    t_init();
    t_bad(32'h0000_1004);
    t_bad(32'h0000_0006);
    end_sim();
  end
endmodule : test_camera_iso_video_packetizer
`default_nettype wire
